// ---- rtl/cluster_dma.sv ----
// Cluster transfer, dual address mode, of one external-bus DMA channel with an APB register slave.
// Assumes an arbiter on bus_req/bus_gnt and an external bus that answers each cycle with ext_ack.
//
// Notes on behaviour
// - Cluster of 1 to 32 bytes read, buffered internally, then written.
// - Dual address cluster mode is used when address mode select is zero.
// - Reads use the source address register, writes the destination address register.
// - All reads of a cluster complete before its writes begin.
// - Cluster size runs from one access unit up to 32 bytes.
// - A one-unit cluster behaves as a dual address block transfer.
// - Bus is held for the whole cluster; nothing else is inserted.
// - Transfer-end output driven only when its enable bit is set.
// - Transfer-end output is active during the final write of the transfer.
// - Transfer acknowledge output is never asserted in this mode.
//
// Local design decisions: the register offsets and the APB slave port.
`include "cluster_dma_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module cluster_dma
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bus_req,
  input wire logic bus_gnt,
  output logic bus_lock,
  output logic [31:0] ext_addr,
  output logic [31:0] ext_wdata,
  input wire logic [31:0] ext_rdata,
  output logic ext_rd,
  output logic ext_wr,
  output cluster_dma_pkg::access_size_type ext_size,
  input wire logic ext_ack,
  output logic transfer_end_out_n,
  output logic transfer_acknowledge_out_n,
  output logic irq
);
  import cluster_dma_pkg::*;

  typedef struct packed
  {
    dma_state_type st;
    logic en;
    logic address_mode_select;
    logic transfer_end_out_enable;
    access_size_type asize;
    logic [31:0] source_address_reg;
    logic [31:0] destination_address_reg;
    logic [5:0] csize;
    logic [15:0] count;
    logic [1:0] istat;
    logic [1:0] imask;
    logic [4:0] idx;
    logic [5:0] nacc;
    logic [31:0][31:0] cbuf;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic rd;
    logic wr;
    logic req;
    logic tend;
    logic [31:0] rdata;
  } state_type;

  state_type cur_ff;
  state_type nxt_ff;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] unit_bytes(input access_size_type sz);
    case (sz)
      SZ_BYTE: unit_bytes = 3'h1;
      SZ_WORD: unit_bytes = 3'h2;
      default: unit_bytes = 3'h4;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      `CTRL_OFF, `SRC_OFF, `DST_OFF, `CSIZE_OFF, `COUNT_OFF, `STATUS_OFF, `ISTAT_OFF, `IMASK_OFF:
        reg_hit = 1'b1;
      default:
        reg_hit = 1'b0;
    endcase
  endfunction

  logic setup_ph;
  logic wr_en;
  logic [1:0] iset;
  logic [1:0] iclr;
  logic last_acc;
  logic [5:0] accs;

  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pwrite && reg_hit(paddr);
  assign last_acc = ({1'b0, cur_ff.idx} == cur_ff.nacc - 6'h01);

  // Accesses per cluster: cluster bytes over unit size, never below one
  // one-unit cluster
  always_comb
  begin
    case (cur_ff.asize)
      SZ_BYTE: accs = cur_ff.csize;
      SZ_WORD: accs = {1'b0, cur_ff.csize[5:1]};
      default: accs = {2'b00, cur_ff.csize[5:2]};
    endcase
    if (accs == 6'h00)
      accs = 6'h01;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_ff = cur_ff;
    iset = 2'b00;
    iclr = 2'b00;

    // Read data latched in setup so prdata comes from a flop
    if (setup_ph)
    begin
      case (paddr)
        `CTRL_OFF: nxt_ff.rdata = {26'h0, cur_ff.asize, 1'b0, cur_ff.transfer_end_out_enable,
                                   cur_ff.address_mode_select, cur_ff.en};
        `SRC_OFF: nxt_ff.rdata = cur_ff.source_address_reg;
        `DST_OFF: nxt_ff.rdata = cur_ff.destination_address_reg;
        `CSIZE_OFF: nxt_ff.rdata = {26'h0, cur_ff.csize};
        `COUNT_OFF: nxt_ff.rdata = {16'h0, cur_ff.count};
        `STATUS_OFF: nxt_ff.rdata = {31'h0, cur_ff.st != ST_IDLE};
        `ISTAT_OFF: nxt_ff.rdata = {30'h0, cur_ff.istat};
        `IMASK_OFF: nxt_ff.rdata = {30'h0, cur_ff.imask};
        default: nxt_ff.rdata = 32'h0;
      endcase
    end

    // Software writes; setup registers frozen while a transfer runs
    if (wr_en)
    begin
      case (paddr)
        `CTRL_OFF:
        begin
          if (cur_ff.st == ST_IDLE)
          begin
            nxt_ff.address_mode_select = pwdata[`CTRL_AMS_BIT];
            nxt_ff.transfer_end_out_enable = pwdata[`CTRL_TEND_BIT];
            nxt_ff.asize = (pwdata[`CTRL_SIZE_LSB+1]) ? SZ_LONG :
                           (pwdata[`CTRL_SIZE_LSB] ? SZ_WORD : SZ_BYTE);
            if (pwdata[`CTRL_EN_BIT] && pwdata[`CTRL_AMS_BIT])
              iset[`ISTAT_MODE_BIT] = 1'b1;
            else
              nxt_ff.en = pwdata[`CTRL_EN_BIT];
          end
          else if (!pwdata[`CTRL_EN_BIT])
          begin
            // Stop takes effect at the next cluster boundary
            nxt_ff.en = 1'b0;
          end
        end
        `SRC_OFF:
          if (cur_ff.st == ST_IDLE)
            nxt_ff.source_address_reg = pwdata;
        `DST_OFF:
          if (cur_ff.st == ST_IDLE)
            nxt_ff.destination_address_reg = pwdata;
        `CSIZE_OFF:
        begin
          if (cur_ff.st != ST_IDLE)
            nxt_ff.csize = cur_ff.csize;
          else if (pwdata > {26'h0, `CSIZE_MAX})
            nxt_ff.csize = `CSIZE_MAX;
          else if (pwdata[5:0] == 6'h00)
            nxt_ff.csize = `CSIZE_RESET;
          else
            nxt_ff.csize = pwdata[5:0];
        end
        `COUNT_OFF:
          if (cur_ff.st == ST_IDLE)
            nxt_ff.count = pwdata[15:0];
        `ISTAT_OFF: iclr = pwdata[1:0];
        `IMASK_OFF: nxt_ff.imask = pwdata[1:0];
        default: nxt_ff.imask = cur_ff.imask;
      endcase
    end

    // ---------------------------------------------------------------
    // Transfer sequencer
    // ---------------------------------------------------------------
    case (cur_ff.st)
      ST_IDLE:
      begin
        if (cur_ff.en && cur_ff.count == 16'h0)
        begin
          nxt_ff.en = 1'b0;
          iset[`ISTAT_DONE_BIT] = 1'b1;
        end
        else if (cur_ff.en && !cur_ff.address_mode_select)
          nxt_ff.st = ST_REQ;
      end
      ST_REQ:
      begin
        nxt_ff.req = 1'b1;
        nxt_ff.nacc = accs;
        nxt_ff.idx = 5'h0;
        if (cur_ff.req && bus_gnt)
          nxt_ff.st = ST_READ;
      end
      ST_READ:
      begin
        if (!cur_ff.rd)
        begin
          nxt_ff.rd = 1'b1;
          nxt_ff.addr = cur_ff.source_address_reg;
        end
        else if (ext_ack)
        begin
          nxt_ff.cbuf[cur_ff.idx] = ext_rdata;
          nxt_ff.rd = 1'b0;
          nxt_ff.source_address_reg = cur_ff.source_address_reg + {29'h0, unit_bytes(cur_ff.asize)};
          if (last_acc)
          begin
            nxt_ff.idx = 5'h0;
            nxt_ff.st = ST_WRITE;
          end
          else
            nxt_ff.idx = cur_ff.idx + 5'h01;
        end
      end
      ST_WRITE:
      begin
        if (!cur_ff.wr)
        begin
          nxt_ff.wr = 1'b1;
          nxt_ff.addr = cur_ff.destination_address_reg;
          nxt_ff.wdata = cur_ff.cbuf[cur_ff.idx];
          nxt_ff.tend = cur_ff.transfer_end_out_enable && cur_ff.count == 16'h1 && last_acc;
        end
        else if (ext_ack)
        begin
          nxt_ff.wr = 1'b0;
          nxt_ff.tend = 1'b0;
          nxt_ff.destination_address_reg = cur_ff.destination_address_reg +
                                           {29'h0, unit_bytes(cur_ff.asize)};
          if (last_acc)
          begin
            nxt_ff.req = 1'b0;
            nxt_ff.count = cur_ff.count - 16'h1;
            nxt_ff.st = ST_NEXT;
          end
          else
            nxt_ff.idx = cur_ff.idx + 5'h01;
        end
      end
      ST_NEXT:
      begin
        if (cur_ff.count == 16'h0 || !cur_ff.en)
        begin
          nxt_ff.en = 1'b0;
          iset[`ISTAT_DONE_BIT] = 1'b1;
          nxt_ff.st = ST_IDLE;
        end
        else
          nxt_ff.st = ST_REQ;
      end
      default:
        nxt_ff.st = ST_IDLE;
    endcase

    // Set beats clear on the same cycle
    nxt_ff.istat = (cur_ff.istat & ~iclr) | iset;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur_ff <= '0;
      cur_ff.st <= ST_IDLE;
      cur_ff.csize <= `CSIZE_RESET;
      cur_ff.count <= `COUNT_RESET;
      cur_ff.nacc <= 6'h01;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = cur_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);
  assign bus_req = cur_ff.req;
  assign bus_lock = cur_ff.req && cur_ff.st != ST_REQ;
  assign ext_addr = cur_ff.addr;
  assign ext_wdata = cur_ff.wdata;
  assign ext_rd = cur_ff.rd;
  assign ext_wr = cur_ff.wr;
  assign ext_size = cur_ff.asize;
  assign transfer_end_out_n = !(cur_ff.tend && cur_ff.transfer_end_out_enable);
  assign transfer_acknowledge_out_n = 1'b1;
  assign irq = |(cur_ff.istat & cur_ff.imask);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  tend_gated_a: assert property (!transfer_end_out_n |-> cur_ff.transfer_end_out_enable)
    else $error("transfer end active while disabled");
  tend_last_a: assert property (!transfer_end_out_n |-> ext_wr && cur_ff.count == 16'h1 && last_acc)
    else $error("transfer end outside final write");
  ack_silent_a: assert property (transfer_acknowledge_out_n)
    else $error("acknowledge strobe asserted");
  lock_held_a: assert property ((ext_rd || ext_wr) |-> bus_lock && bus_req)
    else $error("bus cycle without lock");
  read_first_a: assert property ($rose(ext_rd) |-> cur_ff.st == ST_READ && {1'b0, cur_ff.idx} < cur_ff.nacc)
    else $error("read outside read phase");
  grant_first_a: assert property ((cur_ff.st == ST_REQ) ##1 (cur_ff.st == ST_READ) |-> $past(bus_gnt))
    else $error("read phase without grant");
  release_after_a: assert property ($fell(bus_req) |-> $past(ext_wr) && $past(ext_ack) && cur_ff.st == ST_NEXT)
    else $error("bus released before last write");
  rw_excl_a: assert property (!(ext_rd && ext_wr))
    else $error("read and write together");
  src_used_a: assert property ($rose(ext_rd) |-> ext_addr == cur_ff.source_address_reg)
    else $error("read not from source address");
  dst_used_a: assert property ($rose(ext_wr) |-> ext_addr == cur_ff.destination_address_reg)
    else $error("write not to destination address");
  size_range_a: assert property (cur_ff.csize != 6'h00 && cur_ff.csize <= `CSIZE_MAX)
    else $error("cluster size out of range");
  mode_sel_a: assert property (cur_ff.st != ST_IDLE |-> !cur_ff.address_mode_select)
    else $error("transfer running in single address mode");
  unit_one_a: assert property ((cur_ff.st == ST_READ && cur_ff.nacc == 6'h1 && ext_ack && ext_rd)
                               |=> cur_ff.st == ST_WRITE)
    else $error("one-unit cluster not a single read and write");

endmodule

`default_nettype wire

// ---- rtl/cluster_dma_regs.svh ----
// Register offsets, field positions, reset values and limits of the cluster DMA channel.
// Assumes a 32-bit APB with byte addresses and one aligned word per register.
`ifndef CLUSTER_DMA_REGS_SVH
`define CLUSTER_DMA_REGS_SVH

`define CTRL_OFF        8'h00
`define SRC_OFF         8'h04
`define DST_OFF         8'h08
`define CSIZE_OFF       8'h0C
`define COUNT_OFF       8'h10
`define STATUS_OFF      8'h14
`define ISTAT_OFF       8'h18
`define IMASK_OFF       8'h1C

`define CTRL_EN_BIT     0
`define CTRL_AMS_BIT    1
`define CTRL_TEND_BIT   2
`define CTRL_SIZE_LSB   4

`define ISTAT_DONE_BIT  0
`define ISTAT_MODE_BIT  1

`define CSIZE_MAX       6'h20
`define CSIZE_RESET     6'h01
`define COUNT_RESET     16'h0001

`endif

// ---- rtl/cluster_dma_pkg.sv ----
// Types shared by the cluster DMA channel.
// Assumes nothing beyond a SystemVerilog compiler.
package cluster_dma_pkg;

  // Gray along idle, request, read, write, next
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_REQ   = 3'h1,
    ST_READ  = 3'h3,
    ST_WRITE = 3'h2,
    ST_NEXT  = 3'h6
  } dma_state_type;

  // Data access unit: byte, word, longword
  typedef enum logic [1:0]
  {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } access_size_type;

endpackage

// ---- verif/ext_mem_model.sv ----
// External bus partner: arbiter plus memory that answers each access after a set wait.
// Assumes one cluster DMA master and a bench that chooses the wait per transfer.
`timescale 1ns/1ps
`default_nettype none

module ext_mem_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] wait_cycles,
  input wire logic bus_req,
  output logic bus_gnt,
  input wire logic [31:0] ext_addr,
  input wire logic [31:0] ext_wdata,
  output logic [31:0] ext_rdata,
  input wire logic ext_rd,
  input wire logic ext_wr,
  output logic ext_ack
);
  logic [3:0] cnt_ff;
  logic [31:0] last_ff;
  logic busy;

  assign busy = ext_rd | ext_wr;
  // Released read bus shows the inverse of the last word, so stale data never matches
  assign ext_rdata = ext_rd ? {ext_addr[15:0] ^ 16'h5A3C, ext_addr[15:0]} : ~last_ff;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= 4'h0;
      bus_gnt <= 1'b0;
      ext_ack <= 1'b0;
      last_ff <= 32'h0;
    end
    else
    begin
      if (ext_ack | !(busy | (bus_req & !bus_gnt)))
        cnt_ff <= 4'h0;
      else if (cnt_ff != 4'hF)
        cnt_ff <= cnt_ff + 4'h1;
      // Grant held as long as the request stands
      bus_gnt <= bus_req & (bus_gnt | (cnt_ff >= wait_cycles));
      ext_ack <= busy & !ext_ack & (cnt_ff >= wait_cycles);
      if (busy & ext_ack)
        last_ff <= ext_rd ? ext_rdata : ext_wdata;
    end
  end
endmodule
`default_nettype wire

// ---- verif/cluster_dma_test.sv ----
// Self-checking bench for the cluster DMA channel: APB master, access notes, monitor.
// Assumes ext_mem_model as the external bus and arbiter.
`timescale 1ns/1ps
`default_nettype none
`include "cluster_dma_regs.svh"

module cluster_dma_test;
  import cluster_dma_pkg::*;
  typedef struct packed {logic wr; logic [31:0] addr; logic [31:0] data; logic tend_n; logic [1:0] size;} note_type;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, bus_req, bus_gnt, bus_lock;
  logic ext_rd, ext_wr, ext_ack, transfer_end_out_n, transfer_acknowledge_out_n, irq, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, ext_addr, ext_wdata, ext_rdata, seed, rd, src, dst;
  logic [3:0] wait_cycles;
  access_size_type ext_size;
  note_type q[$];
  note_type nt;
  int mismatches, compares, i, k, j, n, ub, m;
  // Cases: one unit, rounding down, 32 bytes, clamp above 32
  logic [1:0] t_unit [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1};
  logic [5:0] t_cs [6] = '{6'h01, 6'h08, 6'h20, 6'h28, 6'h03, 6'h05};
  logic [3:0] t_cnt [6] = '{4'h1, 4'h2, 4'h2, 4'h1, 4'h2, 4'h1};
  logic t_tend [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  cluster_dma dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_req(bus_req), .bus_gnt(bus_gnt),
    .bus_lock(bus_lock), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .ext_rd(ext_rd),
    .ext_wr(ext_wr), .ext_size(ext_size), .ext_ack(ext_ack), .transfer_end_out_n(transfer_end_out_n),
    .transfer_acknowledge_out_n(transfer_acknowledge_out_n), .irq(irq));

  ext_mem_model far (.clk(clk), .rst(rst), .wait_cycles(wait_cycles), .bus_req(bus_req), .bus_gnt(bus_gnt),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .ext_rd(ext_rd), .ext_wr(ext_wr),
    .ext_ack(ext_ack));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [31:0] fd(input logic [31:0] a);
    return {a[15:0] ^ 16'h5A3C, a[15:0]};
  endfunction

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic test_done;
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && t < 50)
    begin
      t++;
      @(posedge clk);
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(t < 50, "apb hang");
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog, monitor
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    #200000;
    mismatches++;
    test_done;
  end

  always @(posedge clk)
  begin
    if (rst === 1'b0)
    begin
      chk(transfer_acknowledge_out_n === 1'b1, "ack strobe driven");
      chk(transfer_end_out_n === 1'b1 || ext_wr === 1'b1, "end strobe outside write");
      if ((ext_rd | ext_wr) === 1'b1 && ext_ack === 1'b1)
      begin
        if (q.size() == 0)
          chk(1'b0, "unexpected access");
        else
        begin
          nt = q.pop_front();
          chk(ext_wr === nt.wr && ext_addr === nt.addr, "access order or address");
          chk(!nt.wr || ext_wdata === nt.data, "buffered data");
          chk(transfer_end_out_n === nt.tend_n, "end strobe");
          chk(ext_size === access_size_type'(nt.size), "access size");
          chk(bus_lock === 1'b1 && bus_req === 1'b1 && bus_gnt === 1'b1, "bus not held");
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wait_cycles = 4'h0;
    seed = 32'h0000_0023;
    mismatches = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `CSIZE_OFF, 32'h0);
    chk(rd === {26'h0, `CSIZE_RESET}, "size reset");
    apb(1'b0, `COUNT_OFF, 32'h0);
    chk(rd === {16'h0, `COUNT_RESET}, "count reset");
    apb(1'b1, 8'h20, 32'h0);
    chk(e === 1'b1, "unmapped slave error");
    for (i = 0; i < 6; i++)
    begin
      ub = 1 << t_unit[i];
      n = (t_cs[i] > 6'h20 ? 32 : int'(t_cs[i])) / ub;
      if (n == 0)
        n = 1;
      seed = xs(seed);
      src = seed & 32'hFFFF_FFFC;
      seed = xs(seed);
      dst = seed & 32'hFFFF_FFFC;
      wait_cycles <= (i == 0) ? 4'h0 : seed[3:0] & 4'h3;
      for (k = 0; k < t_cnt[i]; k++)
      begin
        for (j = 0; j < n; j++)
          q.push_back('{1'b0, src + 32'((k * n + j) * ub), 32'h0, 1'b1, t_unit[i]});
        for (j = 0; j < n; j++)
          q.push_back('{1'b1, dst + 32'((k * n + j) * ub), fd(src + 32'((k * n + j) * ub)),
            !(t_tend[i] && k == t_cnt[i] - 1 && j == n - 1), t_unit[i]});
      end
      apb(1'b1, `SRC_OFF, src);
      apb(1'b1, `DST_OFF, dst);
      apb(1'b1, `CSIZE_OFF, {26'h0, t_cs[i]});
      apb(1'b1, `COUNT_OFF, 32'(t_cnt[i]));
      apb(1'b1, `IMASK_OFF, 32'(i % 2));
      apb(1'b1, `CTRL_OFF, 32'h1 | (32'(t_tend[i]) << `CTRL_TEND_BIT) | (32'(t_unit[i]) << `CTRL_SIZE_LSB));
      m = 0;
      rd = 32'h0;
      while (rd[`ISTAT_DONE_BIT] !== 1'b1 && m < 300)
      begin
        m++;
        apb(1'b0, `ISTAT_OFF, 32'h0);
      end
      chk(q.size() == 0, "cluster incomplete");
      chk(irq === (i % 2 == 1), "masked irq");
      apb(1'b1, `ISTAT_OFF, 32'h3);
      apb(1'b0, `ISTAT_OFF, 32'h0);
      chk(rd === 32'h0 && irq === 1'b0, "status clear");
    end
    // Zero clusters: done at once, no bus access
    apb(1'b1, `COUNT_OFF, 32'h0);
    apb(1'b1, `CTRL_OFF, 32'h1);
    apb(1'b0, `ISTAT_OFF, 32'h0);
    chk(rd[`ISTAT_DONE_BIT] === 1'b1 && q.size() == 0, "empty transfer done");
    // Only the mode error is let through to irq
    apb(1'b1, `IMASK_OFF, 32'h2);
    apb(1'b1, `CTRL_OFF, 32'h3);
    apb(1'b0, `ISTAT_OFF, 32'h0);
    chk(rd[`ISTAT_MODE_BIT] === 1'b1 && bus_req === 1'b0 && irq === 1'b1, "single address start");
    test_done;
  end
endmodule
`default_nettype wire
